/* File: rtl/aar_result_regs.sv */
// What this block does
// RULE1: Results clear at reset; host writes ignored.
// RULE2: Finished conversion lands in its input's register.
// RULE3: Results right-justified, bits 15 to 12 zero.
// RULE4: Busy/stop bit decoded separately for read, write.
// RULE5: Host writes reserved top bit zero; reads zero.
// RULE6: Busy/stop reads 0 busy, 1 idle.
// RULE7: Writing stop aborts and powers down converter.
// RULE8: Command word: direction, page, location fields.
// RULE9: Pointer advances; past page end reads ones.
// RULE10: Width field selects 12, 8 or 10 bits.
// RULE11: Done output low until scanned results read.
module aar_result_regs
(
   // Clock and reset.
   input wire logic sysClk,
   input wire logic reset,
   // Serial control port pins.
   input wire logic serialClk,
   input wire logic selectN,
   input wire logic serialIn,
   output logic serialOut,
   // Converter core.
   output aar_pkg::aar_conv_req_t convReq,
   input wire aar_pkg::aar_conv_res_t convRes,
   output logic powerDown,
   output logic conversionDoneOutputN
);

   // ==========================================================================
   // Helpers.

   // Maps a data page location to a result index; bit 3 marks a hit.
   function automatic logic [3:0] addrToIdx(input logic [5:0] addr);
      case (addr)
         aar_pkg::ADDR_BATTERY: addrToIdx = {1'b1, aar_pkg::IDX_BATTERY};
         aar_pkg::ADDR_AUX_A: addrToIdx = {1'b1, aar_pkg::IDX_AUX_A};
         aar_pkg::ADDR_AUX_B: addrToIdx = {1'b1, aar_pkg::IDX_AUX_B};
         aar_pkg::ADDR_TEMP_A: addrToIdx = {1'b1, aar_pkg::IDX_TEMP_A};
         aar_pkg::ADDR_TEMP_B: addrToIdx = {1'b1, aar_pkg::IDX_TEMP_B};
         default: addrToIdx = 4'h0;
      endcase
   endfunction : addrToIdx

   // Set of inputs converted by a scan mode; reserved modes convert nothing.
   function automatic logic [4:0] scanSet(input logic [3:0] mode);
      case (mode)
         aar_pkg::SCAN_BATTERY: scanSet = aar_pkg::SET_BATTERY;
         aar_pkg::SCAN_AUX_B: scanSet = aar_pkg::SET_AUX_B;
         aar_pkg::SCAN_AUX_A: scanSet = aar_pkg::SET_AUX_A;
         aar_pkg::SCAN_AUTO: scanSet = aar_pkg::SET_AUTO;
         aar_pkg::SCAN_TEMP_A: scanSet = aar_pkg::SET_TEMP_A;
         aar_pkg::SCAN_PORT: scanSet = aar_pkg::SET_PORT;
         aar_pkg::SCAN_TEMP_B: scanSet = aar_pkg::SET_TEMP_B;
         default: scanSet = 5'h00;
      endcase
   endfunction : scanSet

   // Lowest pending input index.
   function automatic logic [2:0] lowest(input logic [4:0] set);
      lowest = 3'h0;
      for (int i = aar_pkg::NUM_RES - 1; i >= 0; i--)
      begin
         if (set[i])
         begin
            lowest = 3'(i);
         end
      end
   endfunction : lowest

   // ==========================================================================
   // State and combinational terms.
   aar_pkg::aar_regs_state_t s;
   aar_pkg::aar_regs_state_t n;
   aar_pkg::aar_mem_port_t memPort;
   logic [11:0] memData;
   logic selected;
   logic sclkRise;
   logic sclkFall;
   logic wordDone;
   logic [15:0] wordIn;
   logic busy;
   logic [3:0] curHit;
   logic [15:0] readValue;
   logic [11:0] scaled;
   logic [1:0] widthCode;
   logic [4:0] clrMask;
   logic [4:0] setNow;
   logic [3:0] nextHit;

   aar_result_mem u_mem
   (
      .sysClk(sysClk),
      .reset(reset),
      .memPort(memPort),
      .rdData(memData)
   );

   // Serial edges come from the second and third synchroniser stages only.
   assign selected = ~s.selSync[1];
   assign sclkRise = s.clkSync[1] & ~s.clkSync[2];
   assign sclkFall = ~s.clkSync[1] & s.clkSync[2];
   assign wordIn = {s.shiftIn[14:0], s.dinSync[1]};
   assign wordDone = selected & sclkRise & (s.bitCnt == aar_pkg::BIT_LAST);
   assign busy = (s.cv == aar_pkg::AAR_CV_WAIT) || (s.pending != 5'h00);
   assign curHit = addrToIdx(s.ptr[5:0]);
   assign widthCode = s.ctrl[aar_pkg::CTL_WIDTH_LSB +: 2];

   // Read word for the current location; busy/stop reads the idle state.
   always_comb
   begin
      readValue = 16'h0000;
      if (s.ptr[6])
      begin
         readValue = aar_pkg::PAST_END_VALUE; // RULE9
      end
      else if (s.page == aar_pkg::PAGE_DATA && curHit[3])
      begin
         readValue = {4'h0, memData}; // RULE3
      end
      else if (s.page == aar_pkg::PAGE_CTRL && s.ptr[5:0] == aar_pkg::ADDR_CONTROL)
      begin
         readValue = {1'b0, ~busy, s.ctrl}; // RULE4 RULE5 RULE6
      end
      else if (s.page == aar_pkg::PAGE_CTRL && s.ptr[5:0] == aar_pkg::ADDR_STATUS)
      begin
         readValue = {s.davFunc, s.powerDown, 13'h0000};
      end
   end

   // Raw converter word scaled down to the selected width, right-justified.
   always_comb
   begin
      unique case (widthCode)
         aar_pkg::WIDTH_8: scaled = {4'h0, convRes.data[11:4]}; // RULE10
         aar_pkg::WIDTH_10: scaled = {2'h0, convRes.data[11:2]}; // RULE10
         default: scaled = convRes.data;
      endcase
   end

   // Next state: serial framing, register access and conversion sequencing.
   always_comb
   begin
      n = s;
      n.start = 1'b0;
      n.loadNow = 1'b0;
      clrMask = 5'h00;
      setNow = 5'h00;
      memPort = '0;
      n.clkSync = {s.clkSync[1:0], serialClk};
      n.selSync = {s.selSync[0], selectN};
      n.dinSync = {s.dinSync[0], serialIn};

      // Conversion sequencer: one input at a time, lowest index first.
      unique case (s.cv)
         aar_pkg::AAR_CV_IDLE:
         begin
            if (s.pending != 5'h00 && !s.powerDown)
            begin
               n.cur = lowest(s.pending);
               n.start = 1'b1;
               n.cv = aar_pkg::AAR_CV_WAIT;
            end
         end
         aar_pkg::AAR_CV_WAIT:
         begin
            if (convRes.done)
            begin
               memPort.wrEn = 1'b1; // RULE2
               memPort.wrIdx = s.cur; // RULE2
               memPort.wrData = scaled;
               n.pending = s.pending & ~(5'h01 << s.cur);
               n.setMask = s.setMask | (5'h01 << s.cur);
               n.cv = aar_pkg::AAR_CV_IDLE;
               if (n.pending == 5'h00)
               begin
                  setNow = n.setMask; // RULE11
                  n.setMask = 5'h00;
                  if (s.ctrl[aar_pkg::CTL_SCAN_LSB +: 4] == aar_pkg::SCAN_AUTO)
                  begin
                     n.pending = aar_pkg::SET_AUTO;
                  end
               end
            end
         end
      endcase

      // Serial port: mode 0, most significant bit first.
      if (!selected)
      begin
         n.phase = aar_pkg::AAR_PH_CMD;
         n.bitCnt = 4'h0;
         n.dout = 1'b0;
      end
      else
      begin
         if (sclkRise)
         begin
            n.shiftIn = wordIn;
            n.bitCnt = s.bitCnt + 4'h1;
         end
         if (sclkFall)
         begin
            n.dout = s.shiftOut[15];
            n.shiftOut = {s.shiftOut[14:0], 1'b0};
         end
         if (wordDone && s.phase == aar_pkg::AAR_PH_CMD)
         begin
            n.phase = aar_pkg::AAR_PH_DATA;
            n.isRead = wordIn[aar_pkg::CMD_DIR_POS]; // RULE8
            n.page = wordIn[aar_pkg::CMD_PAGE_LSB +: 4]; // RULE8
            n.ptr = {1'b0, wordIn[aar_pkg::CMD_ADDR_LSB +: 6]}; // RULE8
            n.loadNow = wordIn[aar_pkg::CMD_DIR_POS];
         end
         else if (wordDone)
         begin
            n.ptr = s.ptr[6] ? s.ptr : s.ptr + 7'h01; // RULE9
            n.loadNow = s.isRead;
            // Only the control page takes writes; result registers ignore them.
            if (!s.isRead && !s.ptr[6] && s.page == aar_pkg::PAGE_CTRL) // RULE1
            begin
               if (s.ptr[5:0] == aar_pkg::ADDR_STATUS)
               begin
                  n.davFunc = wordIn[aar_pkg::STS_DAV_LSB +: 2];
               end
               else if (s.ptr[5:0] == aar_pkg::ADDR_CONTROL)
               begin
                  n.ctrl = wordIn[13:0] & aar_pkg::CTL_WRITE_MASK;
                  n.cv = aar_pkg::AAR_CV_IDLE;
                  n.start = 1'b0;
                  n.setMask = 5'h00;
                  setNow = 5'h00;
                  if (wordIn[aar_pkg::CTL_BUSY_STOP_POS]) // RULE4
                  begin
                     n.powerDown = 1'b1; // RULE7
                     n.pending = 5'h00; // RULE7
                  end
                  else
                  begin
                     n.powerDown = 1'b0; // RULE7
                     n.pending = scanSet(wordIn[aar_pkg::CTL_SCAN_LSB +: 4]);
                  end
               end
            end
         end
         if (s.loadNow)
         begin
            n.shiftOut = readValue;
            if (s.page == aar_pkg::PAGE_DATA && !s.ptr[6] && curHit[3])
            begin
               clrMask = 5'h01 << curHit[2:0];
            end
         end
      end

      // New completions win over a clearing read in the same cycle.
      n.unread = (s.unread & ~clrMask) | setNow; // RULE11
      n.davN = !(n.davFunc == aar_pkg::DAV_FUNC_AVAIL && n.unread != 5'h00); // RULE11
      // Memory read index follows the next pointer so read data stand at the load.
      nextHit = addrToIdx(n.ptr[5:0]);
      memPort.rdIdx = nextHit[3] ? nextHit[2:0] : 3'h0;

      if (reset)
      begin
         n = '0;
         n.clkSync = 3'h0;
         n.selSync = 2'h3;
         n.ctrl = aar_pkg::CTL_RESET;
         n.davFunc = aar_pkg::STS_DAV_RESET;
         n.davN = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge sysClk)
   begin
      s <= n;
   end

   // Outputs straight from state flip-flops.
   assign serialOut = s.dout;
   assign convReq = '{start: s.start, channel: s.cur, width: widthCode};
   assign powerDown = s.powerDown;
   assign conversionDoneOutputN = s.davN;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge sysClk);
   endclocking
   default disable iff (reset);

   a_result_upper_zero: assert property (s.loadNow && s.page == aar_pkg::PAGE_DATA && !s.ptr[6]
      |=> s.shiftOut[15:12] == 4'h0) // RULE3
      else $error("Result word upper bits not zero.");

   a_busy_reads_zero: assert property (s.loadNow && s.cv == aar_pkg::AAR_CV_WAIT && !s.ptr[6]
      && s.page == aar_pkg::PAGE_CTRL && s.ptr[5:0] == aar_pkg::ADDR_CONTROL
      |=> s.shiftOut[15:14] == 2'b00) // RULE6
      else $error("Busy/stop or reserved bit wrong while busy.");

   a_idle_reads_one: assert property (s.loadNow && !busy && !s.ptr[6]
      && s.page == aar_pkg::PAGE_CTRL && s.ptr[5:0] == aar_pkg::ADDR_CONTROL
      |=> s.shiftOut[15:14] == 2'b01) // RULE6
      else $error("Busy/stop bit not one while idle.");

   a_stop_powers_down: assert property (wordDone && s.phase == aar_pkg::AAR_PH_DATA && !s.isRead
      && !s.ptr[6] && s.page == aar_pkg::PAGE_CTRL && s.ptr[5:0] == aar_pkg::ADDR_CONTROL
      && wordIn[aar_pkg::CTL_BUSY_STOP_POS]
      |=> powerDown && !convReq.start && s.pending == 5'h00 ##1 s.cv == aar_pkg::AAR_CV_IDLE) // RULE7
      else $error("Stop write did not abort and power down.");

   a_command_decode: assert property (wordDone && s.phase == aar_pkg::AAR_PH_CMD
      |=> s.page == $past(wordIn[14:11]) && s.ptr == {1'b0, $past(wordIn[10:5])}
      && s.isRead == $past(wordIn[15])) // RULE8
      else $error("Command word not decoded.");

   a_past_end_ones: assert property (s.loadNow && s.ptr[6] |=> s.shiftOut == 16'hffff) // RULE9
      else $error("Read past page end not all ones.");

   a_pointer_bound: assert property (s.ptr <= aar_pkg::PTR_PAST_END) // RULE9
      else $error("Location pointer beyond page end.");

   a_width_eight: assert property (memPort.wrEn && widthCode == aar_pkg::WIDTH_8
      |-> memPort.wrData[11:8] == 4'h0) // RULE10
      else $error("Eight-bit result not right-justified.");

   a_no_host_result_write: assert property (memPort.wrEn
      |-> s.cv == aar_pkg::AAR_CV_WAIT && convRes.done) // RULE1
      else $error("Result written without a finished conversion.");

   a_done_goes_low: assert property (setNow != 5'h00 && s.davFunc == aar_pkg::DAV_FUNC_AVAIL
      |=> !conversionDoneOutputN [*2]) // RULE11
      else $error("Done output not low after completed set.");

   a_done_has_cause: assert property (!conversionDoneOutputN
      |-> s.unread != 5'h00 && s.davFunc == aar_pkg::DAV_FUNC_AVAIL) // RULE11
      else $error("Done output low with nothing unread.");

endmodule : aar_result_regs

/* File: inc/aar_pkg.sv */
package aar_pkg;

   // ==========================================================================
   // Serial command word layout and word framing.
   localparam int WORD_BITS = 16;
   localparam int CMD_DIR_POS = 15;
   localparam int CMD_PAGE_LSB = 11;
   localparam int CMD_ADDR_LSB = 5;
   localparam logic [3:0] BIT_LAST = 4'hf;
   localparam logic [6:0] PTR_PAST_END = 7'h40;
   localparam logic [15:0] PAST_END_VALUE = 16'hffff;

   // ==========================================================================
   // Pages and locations.
   localparam logic [3:0] PAGE_DATA = 4'h0;
   localparam logic [3:0] PAGE_CTRL = 4'h1;
   localparam logic [5:0] ADDR_BATTERY = 6'h05;
   localparam logic [5:0] ADDR_AUX_A = 6'h07;
   localparam logic [5:0] ADDR_AUX_B = 6'h08;
   localparam logic [5:0] ADDR_TEMP_A = 6'h09;
   localparam logic [5:0] ADDR_TEMP_B = 6'h0a;
   localparam logic [5:0] ADDR_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h01;

   // ==========================================================================
   // Result storage: one entry per measured input, index order below.
   localparam int RES_BITS = 12;
   localparam int NUM_RES = 5;
   localparam logic [2:0] IDX_BATTERY = 3'h0;
   localparam logic [2:0] IDX_AUX_A = 3'h1;
   localparam logic [2:0] IDX_AUX_B = 3'h2;
   localparam logic [2:0] IDX_TEMP_A = 3'h3;
   localparam logic [2:0] IDX_TEMP_B = 3'h4;
   localparam logic [11:0] RES_RESET = 12'h000;

   // ==========================================================================
   // Converter control and status fields.
   localparam int CTL_BUSY_STOP_POS = 14;
   localparam int CTL_SCAN_LSB = 10;
   localparam int CTL_WIDTH_LSB = 8;
   localparam logic [13:0] CTL_WRITE_MASK = 14'h3ff1;
   localparam logic [13:0] CTL_RESET = 14'h0000;
   localparam int STS_DAV_LSB = 14;
   localparam logic [1:0] STS_DAV_RESET = 2'h2;
   localparam logic [1:0] DAV_FUNC_AVAIL = 2'h1;
   localparam logic [1:0] WIDTH_8 = 2'h1;
   localparam logic [1:0] WIDTH_10 = 2'h2;

   // ==========================================================================
   // Scan modes and the set of inputs that each converts.
   localparam logic [3:0] SCAN_BATTERY = 4'h6;
   localparam logic [3:0] SCAN_AUX_B = 4'h7;
   localparam logic [3:0] SCAN_AUX_A = 4'h8;
   localparam logic [3:0] SCAN_AUTO = 4'h9;
   localparam logic [3:0] SCAN_TEMP_A = 4'ha;
   localparam logic [3:0] SCAN_PORT = 4'hb;
   localparam logic [3:0] SCAN_TEMP_B = 4'hc;
   localparam logic [4:0] SET_BATTERY = 5'h01;
   localparam logic [4:0] SET_AUX_A = 5'h02;
   localparam logic [4:0] SET_AUX_B = 5'h04;
   localparam logic [4:0] SET_TEMP_A = 5'h08;
   localparam logic [4:0] SET_TEMP_B = 5'h10;
   localparam logic [4:0] SET_AUTO = 5'h1e;
   localparam logic [4:0] SET_PORT = 5'h07;

   // ==========================================================================
   // Types.
   typedef enum logic [0:0] {AAR_PH_CMD = 1'b0, AAR_PH_DATA = 1'b1} aar_phase_t;
   typedef enum logic [0:0] {AAR_CV_IDLE = 1'b0, AAR_CV_WAIT = 1'b1} aar_conv_t;

   typedef struct packed {
      logic start;
      logic [2:0] channel;
      logic [1:0] width;
   } aar_conv_req_t;

   typedef struct packed {
      logic done;
      logic [11:0] data;
   } aar_conv_res_t;

   typedef struct packed {
      logic wrEn;
      logic [2:0] wrIdx;
      logic [11:0] wrData;
      logic [2:0] rdIdx;
   } aar_mem_port_t;

   typedef struct packed {
      logic [4:0][11:0] entry;
      logic [11:0] rdData;
   } aar_mem_state_t;

   typedef struct packed {
      logic [2:0] clkSync;
      logic [1:0] selSync;
      logic [1:0] dinSync;
      aar_phase_t phase;
      logic [3:0] bitCnt;
      logic [15:0] shiftIn;
      logic [15:0] shiftOut;
      logic isRead;
      logic [3:0] page;
      logic [6:0] ptr;
      logic loadNow;
      logic dout;
      logic [13:0] ctrl;
      logic [1:0] davFunc;
      logic powerDown;
      aar_conv_t cv;
      logic [4:0] pending;
      logic [4:0] setMask;
      logic [4:0] unread;
      logic [2:0] cur;
      logic start;
      logic davN;
   } aar_regs_state_t;

endpackage : aar_pkg

/* File: rtl/aar_result_mem.sv */
module aar_result_mem
(
   // Clock and reset.
   input wire logic sysClk,
   input wire logic reset,
   // Write and read requests.
   input wire aar_pkg::aar_mem_port_t memPort,
   // Registered read data.
   output logic [11:0] rdData
);

   // ==========================================================================
   // State.
   aar_pkg::aar_mem_state_t s;
   aar_pkg::aar_mem_state_t n;
   logic [4:0][11:0] nextEntry;

   // Each entry takes the converter word only when it is addressed.
   genvar gi;
   generate
      for (gi = 0; gi < aar_pkg::NUM_RES; gi++)
      begin : g_entry
         assign nextEntry[gi] = (memPort.wrEn && memPort.wrIdx == 3'(gi)) ? memPort.wrData : s.entry[gi];
      end
   endgenerate

   // Next state: results clear at reset, read data come out of a register.
   always_comb
   begin
      n = s;
      n.entry = nextEntry;
      n.rdData = (memPort.rdIdx < 3'(aar_pkg::NUM_RES)) ? s.entry[memPort.rdIdx] : aar_pkg::RES_RESET;
      if (reset)
      begin
         n = '0; // RULE1
      end
   end

   // State register.
   always_ff @(posedge sysClk)
   begin
      s <= n;
   end

   assign rdData = s.rdData;

   // ==========================================================================
   // Checks.
   a_reset_clears: assert property (@(posedge sysClk) reset |=> (s.entry == '0)) // RULE1
      else $error("Result entries not cleared by reset.");

   a_result_stored: assert property (@(posedge sysClk) disable iff (reset)
      memPort.wrEn |=> (s.entry[$past(memPort.wrIdx)] == $past(memPort.wrData))) // RULE2
      else $error("Converter result not stored in its entry.");

endmodule : aar_result_mem

/* File: tb/aar_host_model.sv */
// ==========================================
// Host processor model on the serial control port.
module aar_host_model
(
   // Clock.
   input wire logic sysClk,
   // Serial pins toward the device.
   output logic serialClk,
   output logic selectN,
   output logic serialIn,
   input wire logic serialOut,
   // Captured read words.
   output logic rxValid,
   output logic [15:0] rxWord
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle with the clock low and the frame deselected.
   initial
   begin
      serialClk = 1'b0;
      selectN = 1'b1;
      serialIn = 1'b0;
      rxValid = 1'b0;
      rxWord = 16'h0000;
   end

   // Each clock phase lasts eight system cycles so the synchroniser sees it.
   task automatic half();
      repeat (8) @(negedge sysClk);
   endtask : half

   // One word, MSB first; read bits are taken just before each rise.
   task automatic word(input logic [15:0] txd, input logic keep);
      logic [15:0] rxd;
      for (int i = 15; i >= 0; i--)
      begin
         serialIn = txd[i];
         half();
         rxd[i] = serialOut;
         serialClk = ~serialClk;
         half();
         serialClk = ~serialClk;
      end
      serialIn = ~txd[0]; // The data line no longer shows the last bit.
      if (keep)
      begin
         rxWord = rxd;
         rxValid = 1'b1;
         @(negedge sysClk);
         rxValid = 1'b0;
      end
   endtask : word

   // Whole frame: command word, then data words; keep marks reported reads.
   task automatic frame(input logic [15:0] cmd, input logic [15:0] d[$], input logic [7:0] keep);
      selectN = 1'b0;
      half();
      word(cmd, 1'b0);
      foreach (d[i])
         word(d[i], keep[i]);
      half();
      selectN = 1'b1;
      half();
   endtask : frame

endmodule : aar_host_model

/* File: tb/aar_result_regs_tb.sv */
`define CHK(a, e) \
   begin \
      logic [31:0] chkGot; \
      logic [31:0] chkExp; \
      chkGot = 32'(a); \
      chkExp = 32'(e); \
      checkCount++; \
      if (chkGot !== chkExp) \
      begin \
         badCount++; \
         $display("wrong value at %0t: got %h expected %h", $time, chkGot, chkExp); \
      end \
   end

// ==========================================
// Self-checking bench for the result register block.
module aar_result_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic sysClk;
   logic reset;
   logic serialClk;
   logic selectN;
   logic serialIn;
   logic serialOut;
   aar_pkg::aar_conv_req_t convReq;
   aar_pkg::aar_conv_res_t convRes;
   logic powerDown;
   logic conversionDoneOutputN;
   logic rxValid;
   logic [15:0] rxWord;
   logic [15:0] expQ[$];
   logic [15:0] expRes[5] = '{default: 16'h0000};
   logic [3:0] modes[6] = '{aar_pkg::SCAN_BATTERY, aar_pkg::SCAN_AUX_B, aar_pkg::SCAN_AUX_A,
      aar_pkg::SCAN_TEMP_A, aar_pkg::SCAN_TEMP_B, aar_pkg::SCAN_PORT};
   logic [4:0] sets[6] = '{aar_pkg::SET_BATTERY, aar_pkg::SET_AUX_B, aar_pkg::SET_AUX_A,
      aar_pkg::SET_TEMP_A, aar_pkg::SET_TEMP_B, aar_pkg::SET_PORT};
   logic [4:0] expSet = 5'h00;
   logic [1:0] widthSel = 2'h0;
   int badCount = 0;
   int checkCount = 0;
   int cvDelay = 10;

   // Free-running system clock, 4 ns period.
   initial
   begin
      sysClk = 1'b0;
      forever #2 sysClk = ~sysClk;
   end

   aar_result_regs dut (.sysClk(sysClk), .reset(reset), .serialClk(serialClk), .selectN(selectN),
      .serialIn(serialIn), .serialOut(serialOut), .convReq(convReq), .convRes(convRes),
      .powerDown(powerDown), .conversionDoneOutputN(conversionDoneOutputN));

   aar_host_model host (.sysClk(sysClk), .serialClk(serialClk), .selectN(selectN), .serialIn(serialIn),
      .serialOut(serialOut), .rxValid(rxValid), .rxWord(rxWord));

   // Right-justified result word for a raw sample at a given width.
   function automatic logic [15:0] scale(input logic [11:0] r, input logic [1:0] w);
      case (w)
         2'h1: return {8'h00, r[11:4]};
         2'h2: return {6'h00, r[11:2]};
         default: return {4'h0, r};
      endcase
   endfunction : scale

   // Converter stand-in: answers each start after cvDelay, never once stopped.
   initial
   begin : conv_model
      logic [2:0] ch;
      logic [1:0] w;
      logic [11:0] raw;
      convRes = '0;
      forever
      begin
         @(negedge sysClk);
         if (convReq.start === 1'b1)
         begin
            ch = convReq.channel;
            w = widthSel;
            `CHK(expSet[ch], 1'b1)
            `CHK(convReq.width, widthSel)
            repeat (cvDelay) @(negedge sysClk);
            if (powerDown !== 1'b1)
            begin
               raw = 12'($urandom);
               convRes.done = 1'b1;
               convRes.data = raw;
               expRes[ch] = scale(raw, w);
               @(negedge sysClk);
               convRes.done = 1'b0;
               convRes.data = ~raw;
            end
         end
      end
   end

   // Every reported read word is compared with the oldest note.
   always @(posedge sysClk)
      if (rxValid === 1'b1)
         `CHK(rxWord, expQ.pop_front())

   // Read n words starting at a page location.
   task automatic rd(input logic [3:0] pg, input logic [5:0] loc, input int n, input logic [7:0] keep);
      logic [15:0] d[$];
      repeat (n) d.push_back(16'($urandom));
      host.frame({1'b1, pg, loc, 5'h00}, d, keep);
   endtask : rd

   // Write one word to a page location.
   task automatic wr(input logic [3:0] pg, input logic [5:0] loc, input logic [15:0] val);
      logic [15:0] d[$];
      d.push_back(val);
      host.frame({1'b0, pg, loc, 5'h00}, d, 8'h00);
   endtask : wr

   // Read back all five results in one frame, skipping the reserved location.
   task automatic readResults();
      for (int i = 0; i < 5; i++)
         expQ.push_back(expRes[i]);
      rd(aar_pkg::PAGE_DATA, aar_pkg::ADDR_BATTERY, 6, 8'h3d);
   endtask : readResults

   // Counts, verdict and end of run.
   task automatic conclude();
      `CHK(expQ.size(), 0)
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // Watchdog well beyond the expected run length.
   initial
   begin
      #320000;
      badCount++;
      conclude();
   end

   // ==========================================
   // Test sequence.
   initial
   begin : main
      logic [15:0] ctl;
      int k;
      reset = 1'b1;
      repeat (4) @(negedge sysClk);
      reset = 1'b0;
      repeat (4) @(negedge sysClk);
      void'($urandom(32'hef2f));

      readResults();
      expQ.push_back(16'h4000);
      expQ.push_back(16'h8000);
      rd(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 2, 8'h03);
      $display("test reset values done");

      wr(aar_pkg::PAGE_DATA, aar_pkg::ADDR_BATTERY, 16'($urandom));
      readResults();
      expQ.push_back(16'hffff);
      expQ.push_back(16'hffff);
      rd(aar_pkg::PAGE_DATA, 6'h3f, 3, 8'h06);
      $display("test read only and page end done");

      wr(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_STATUS, 16'h4000);
      for (int i = 0; i < 6; i++)
      begin
         ctl = {2'b00, modes[i], 2'(i), 8'($urandom)};
         widthSel = ctl[9:8];
         expSet = sets[i];
         wr(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, ctl);
         k = 0;
         while (conversionDoneOutputN !== 1'b0 && k < 3000)
         begin
            @(negedge sysClk);
            k++;
         end
         `CHK(conversionDoneOutputN, 1'b0)
         expQ.push_back((ctl & 16'h3ff1) | 16'h4000);
         rd(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 1, 8'h01);
         readResults();
         `CHK(conversionDoneOutputN, 1'b1)
      end
      $display("test scan modes done");

      cvDelay = 5000;
      widthSel = 2'h0;
      expSet = aar_pkg::SET_AUTO;
      wr(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, {2'b00, aar_pkg::SCAN_AUTO, 10'h000});
      expQ.push_back({2'b00, aar_pkg::SCAN_AUTO, 10'h000});
      rd(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 1, 8'h01);
      wr(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 16'h4000);
      `CHK(powerDown, 1'b1)
      expQ.push_back(16'h4000);
      expQ.push_back(16'h6000);
      rd(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 2, 8'h03);
      repeat (5100) @(negedge sysClk);
      readResults();
      wr(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 16'h0000);
      `CHK(powerDown, 1'b0)
      $display("test busy and stop done");

      // A second reset in mid-run must restore every reset value.
      reset = 1'b1;
      repeat (4) @(negedge sysClk);
      reset = 1'b0;
      repeat (4) @(negedge sysClk);
      expRes = '{default: 16'h0000};
      `CHK(conversionDoneOutputN, 1'b1)
      `CHK(powerDown, 1'b0)
      readResults();
      expQ.push_back(16'h4000);
      expQ.push_back(16'h8000);
      rd(aar_pkg::PAGE_CTRL, aar_pkg::ADDR_CONTROL, 2, 8'h03);
      $display("test second reset done");
      conclude();
   end

endmodule : aar_result_regs_tb
